//--- rtl/rco_rx_checksum.sv
// Receive checksum offload engine in the MAC receive byte stream
//------------------------------------------------------------
//------------------------------------------------------------
`timescale 1ns/1ps
`include "rco_regs.svh"

module rco_rx_checksum
	import rco_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	input  wire logic        in_valid_i,
	input  wire rco_byte_t   in_byte_i,
	output logic             in_ready_o,
	output logic             out_valid_o,
	output logic      [7:0]  out_data_o,
	output logic             out_last_o,
	output logic             status_valid_o,
	output logic      [15:0] status_len_o
);

	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	rco_regs_t q_r;
	rco_regs_t q_nxt;

	logic        acc;
	logic [15:0] idx;
	logic [15:0] strt;
	logic [15:0] word;
	logic [15:0] sum1;
	logic [15:0] ptype;

	assign in_ready_o     = (q_r.st != RCO_APP1) && (q_r.st != RCO_APP2);
	assign acc            = in_valid_i && in_ready_o;
	assign idx            = (q_r.st == RCO_IDLE) ? 16'h0000 : q_r.cnt;
	assign word           = {in_byte_i.data, q_r.lo};
	assign ptype          = {q_r.prv, in_byte_i.data};
	assign reg_rdata_o    = q_r.rdata;
	assign out_valid_o    = q_r.ov;
	assign out_data_o     = q_r.od;
	assign out_last_o     = q_r.ol;
	assign status_valid_o = q_r.sv;
	assign status_len_o   = q_r.slen;

	// Start offset is fixed per mode until the header is parsed
	assign strt = (q_r.st != RCO_IDLE) ? q_r.start :
	              (q_r.mode ? `RCO_NO_START : `RCO_HDR_LEN);

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb begin
		logic       ph1;
		logic [7:0] lo1;
		ph1   = q_r.ph;
		lo1   = q_r.lo;
		sum1  = (q_r.st == RCO_IDLE) ? 16'h0000 : q_r.sum;
		q_nxt = q_r;
		q_nxt.ov    = 1'b0;
		q_nxt.ol    = 1'b0;
		q_nxt.sv    = 1'b0;
		q_nxt.rdata = 32'h0000_0000;

		if (reg_wr_i) begin
			unique case (reg_addr_i)
				`RCO_CTL_ADDR: begin
					q_nxt.en   = reg_wdata_i[`RCO_EN_BIT];
					q_nxt.mode = reg_wdata_i[`RCO_MODE_BIT];
				end
				`RCO_VLAN_ADDR: q_nxt.vtag = reg_wdata_i[15:0];
				default: ;
			endcase
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`RCO_CTL_ADDR: begin
					q_nxt.rdata[`RCO_EN_BIT]   = q_r.en;
					q_nxt.rdata[`RCO_MODE_BIT] = q_r.mode;
				end
				`RCO_VLAN_ADDR: q_nxt.rdata[15:0] = q_r.vtag;
				`RCO_SUM_ADDR:  q_nxt.rdata[15:0] = q_r.lsum;
				`RCO_CNT_ADDR:  q_nxt.rdata[15:0] = q_r.fcnt;
				default: ;
			endcase
		end

		unique case (q_r.st)
			RCO_IDLE, RCO_RUN: begin
				if (acc) begin
					q_nxt.od    = in_byte_i.data;
					q_nxt.ov    = 1'b1;
					q_nxt.cnt   = idx + `RCO_ONE;
					q_nxt.prv   = in_byte_i.data;
					q_nxt.st    = RCO_RUN;
					q_nxt.start = strt;
					if (q_r.st == RCO_IDLE) begin
						q_nxt.tpos = `RCO_TYPE_POS;
						q_nxt.vlan = 2'h0;
						ph1        = 1'b0;
					end
					if (q_r.mode && !in_byte_i.fcs && (q_r.st == RCO_RUN) &&
					    (idx == q_r.tpos + `RCO_ONE)) begin
						if ((ptype == q_r.vtag) && (q_r.vlan < `RCO_MAX_VLAN)) begin
							q_nxt.tpos = q_r.tpos + `RCO_VLAN_LEN;
							q_nxt.vlan = q_r.vlan + 2'h1;
						end else if (ptype < `RCO_TYPE_MIN) begin
							q_nxt.start = idx + `RCO_ONE + `RCO_SNAP_LEN;
						end else begin
							q_nxt.start = idx + `RCO_ONE;
						end
					end
					if (q_r.en && !in_byte_i.fcs && (idx >= strt)) begin
						if (!ph1) begin
							lo1 = in_byte_i.data;
							ph1 = 1'b1;
						end else begin
							sum1 = rco_add(sum1, word);
							ph1  = 1'b0;
						end
					end
					q_nxt.ph  = ph1;
					q_nxt.lo  = lo1;
					q_nxt.sum = sum1;
					if (in_byte_i.last) begin
						if (q_r.en) begin
							if (ph1) begin
								q_nxt.sum = rco_add(sum1, {8'h00, lo1});
							end
							q_nxt.ph = 1'b0;
							q_nxt.st = RCO_APP1;
						end else begin
							q_nxt.ol   = 1'b1;
							q_nxt.sv   = 1'b1;
							q_nxt.slen = idx + `RCO_ONE;
							q_nxt.fcnt = q_r.fcnt + `RCO_ONE;
							q_nxt.st   = RCO_IDLE;
						end
					end
				end
			end
			RCO_APP1: begin
				q_nxt.od = q_r.sum[7:0];
				q_nxt.ov = 1'b1;
				q_nxt.st = RCO_APP2;
			end
			RCO_APP2: begin
				q_nxt.od   = q_r.sum[15:8];
				q_nxt.ov   = 1'b1;
				q_nxt.ol   = 1'b1;
				q_nxt.sv   = 1'b1;
				q_nxt.slen = q_r.cnt + `RCO_CSUM_BYTES;
				q_nxt.lsum = q_r.sum;
				q_nxt.fcnt = q_r.fcnt + `RCO_ONE;
				q_nxt.st   = RCO_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_r       <= '0;
			q_r.st    <= RCO_IDLE;
			q_r.start <= `RCO_HDR_LEN;
			q_r.tpos  <= `RCO_TYPE_POS;
			q_r.vtag  <= `RCO_VLAN_RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_sum_bytes;
		out_valid_o && !out_last_o ##1 out_valid_o && out_last_o;
	endsequence

	sequence s_frame_tail;
		out_valid_o && !out_last_o ##1 s_sum_bytes;
	endsequence

	AST_APPEND_TWO: assert property (acc && in_byte_i.last && q_r.en |=> s_frame_tail)
		else $error("checksum not appended after frame");

	AST_PASS_DATA: assert property (acc |=> out_valid_o && (out_data_o == $past(in_byte_i.data)))
		else $error("forwarded byte differs from input");

	AST_NO_APPEND: assert property (acc && in_byte_i.last && !q_r.en |=> out_last_o && status_valid_o)
		else $error("disabled engine did not end frame at last byte");

	AST_LEN_PLUS2: assert property (status_valid_o && $past(q_r.st == RCO_APP2) |->
	                                (status_len_o == q_r.cnt + `RCO_CSUM_BYTES))
		else $error("status length not frame length plus two");

	AST_STALL: assert property ((q_r.st == RCO_APP1) |-> !in_ready_o ##1 !in_ready_o)
		else $error("input accepted while appending checksum");

	AST_MODE0_HDR: assert property (acc && !q_r.mode && (idx < `RCO_HDR_LEN) |=>
	                                (q_r.sum == $past(sum1)) && !q_r.ph)
		else $error("mode 0 summed a header byte");

	AST_CARRY: assert property (acc && q_r.en && q_r.ph && (q_r.st == RCO_RUN) && !in_byte_i.fcs &&
	                            !in_byte_i.last && (idx >= strt) |=>
	                            (q_r.sum == rco_add($past(q_r.sum), $past(word))))
		else $error("wrong end-around carry sum");

	AST_VLAN_SKIP: assert property (acc && q_r.mode && (q_r.st == RCO_RUN) && !in_byte_i.fcs &&
	                                (idx == q_r.tpos + `RCO_ONE) && (ptype == q_r.vtag) &&
	                                (q_r.vlan < `RCO_MAX_VLAN) |=>
	                                (q_r.tpos == $past(q_r.tpos) + `RCO_VLAN_LEN))
		else $error("VLAN tag not skipped");

	AST_VLAN_MAX: assert property (q_r.vlan <= `RCO_MAX_VLAN)
		else $error("more than two VLAN tags skipped");

endmodule // rco_rx_checksum

//--- inc/rco_regs.svh
// Register offsets, field positions, reset values and parse constants
`ifndef RCO_REGS_SVH
`define RCO_REGS_SVH
`define RCO_CTL_ADDR    4'h0
`define RCO_VLAN_ADDR   4'h4
`define RCO_SUM_ADDR    4'h8
`define RCO_CNT_ADDR    4'hc
`define RCO_EN_BIT      0
`define RCO_MODE_BIT    1
`define RCO_VLAN_RST    16'h8100
`define RCO_HDR_LEN     16'h000e
`define RCO_TYPE_POS    16'h000c
`define RCO_VLAN_LEN    16'h0004
`define RCO_SNAP_LEN    16'h0008
`define RCO_TYPE_LEN    16'h0002
`define RCO_TYPE_MIN    16'h0600
`define RCO_NO_START    16'hffff
`define RCO_MAX_VLAN    2'h2
`define RCO_CSUM_BYTES  16'h0002
`define RCO_ONE         16'h0001
`endif

//--- inc/rco_pkg.sv
// Types shared by the receive checksum engine
package rco_pkg;
	typedef enum logic [1:0] {
		RCO_IDLE = 2'h0,
		RCO_RUN  = 2'h1,
		RCO_APP1 = 2'h3,
		RCO_APP2 = 2'h2
	} rco_state_t;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
		logic       fcs;
	} rco_byte_t;

	typedef struct packed {
		rco_state_t  st;
		logic [15:0] cnt;
		logic [15:0] start;
		logic [15:0] tpos;
		logic [1:0]  vlan;
		logic [15:0] sum;
		logic [7:0]  lo;
		logic        ph;
		logic [7:0]  prv;
		logic        en;
		logic        mode;
		logic [15:0] vtag;
		logic [31:0] rdata;
		logic [7:0]  od;
		logic        ov;
		logic        ol;
		logic        sv;
		logic [15:0] slen;
		logic [15:0] lsum;
		logic [15:0] fcnt;
	} rco_regs_t;

	function automatic logic [15:0] rco_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] t;
		t = {1'b0, a} + {1'b0, b};
		return t[15:0] + {15'h0000, t[16]};
	endfunction
endpackage

//--- verif/rco_mac_src.sv
// Receive byte source standing in for the MAC receive path
`timescale 1ns/1ps
module rco_mac_src
	import rco_pkg::*;
(
	input  wire logic core_clk_i,
	input  wire logic in_ready_i,
	output logic      in_valid_o,
	output rco_byte_t in_byte_o
);
	logic [7:0] mem [0:63];
	logic       stuck = 1'b0;

	initial begin
		in_valid_o = 1'b0;
		in_byte_o  = '0;
	end

	task automatic send(input int n);
		logic r;
		@(posedge core_clk_i);
		for (int k = 0; k < n; k++) begin
			in_valid_o <= 1'b1;
			in_byte_o  <= '{data: mem[k], last: (k == n - 1), fcs: (k >= n - 4)};
			r = 1'b0;
			for (int w = 0; w < 16; w++) begin
				@(negedge core_clk_i);
				r = in_ready_i;
				@(posedge core_clk_i);
				if (r) break;
			end
			// Byte never taken within the bound
			if (!r) stuck = 1'b1;
		end
		in_valid_o     <= 1'b0;
		in_byte_o.data <= ~mem[n - 1];
	endtask
endmodule // rco_mac_src

//--- verif/rx_checksum_offload_tb.sv
// Self-checking bench for the receive checksum engine
`timescale 1ns/1ps
module rx_checksum_offload_tb
	import rco_pkg::*;
;
	logic        core_clk_i = 1'b0;
	logic        rst_n_i    = 1'b0;
	logic [3:0]  reg_addr   = 4'h0;
	logic [31:0] reg_wdata  = 32'h0;
	logic        reg_wr     = 1'b0;
	logic        reg_rd     = 1'b0;
	logic [31:0] reg_rdata;
	logic        in_valid;
	rco_byte_t   in_byte;
	logic        in_ready, out_valid, out_last, status_valid;
	logic [7:0]  out_data;
	logic [15:0] status_len, slen;
	logic        got = 1'b0;
	logic [7:0]  outq [$];
	int          n_fail = 0;
	int          num_checks = 0;

	always #10 core_clk_i = ~core_clk_i;

	rco_rx_checksum i_rco_rx_checksum (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.in_valid_i(in_valid), .in_byte_i(in_byte), .in_ready_o(in_ready), .out_valid_o(out_valid),
		.out_data_o(out_data), .out_last_o(out_last), .status_valid_o(status_valid), .status_len_o(status_len));
	rco_mac_src i_rco_mac_src (.core_clk_i(core_clk_i), .in_ready_i(in_ready), .in_valid_o(in_valid),
		.in_byte_o(in_byte));

	//------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (e !== g) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge core_clk_i) begin
		if (out_valid === 1'b1) outq.push_back(out_data);
		if (status_valid === 1'b1) begin
			chk("last", 1, out_last);
			slen <= status_len;
			got  <= 1'b1;
		end
	end

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk_i);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk_i);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk_i);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic setb(input int i, input logic [7:0] a, input logic [7:0] b);
		i_rco_mac_src.mem[i]     = a;
		i_rco_mac_src.mem[i + 1] = b;
	endtask

	// Words {second, first}, zero high pad, end-around carry
	function automatic logic [15:0] csum(input int s, input int n);
		logic [16:0] t;
		logic [15:0] a;
		a = 16'h0000;
		for (int i = s; i < n - 4; i += 2) begin
			t = a + {(i + 1 < n - 4) ? i_rco_mac_src.mem[i + 1] : 8'h00, i_rco_mac_src.mem[i]};
			a = t[15:0] + t[16];
		end
		return a;
	endfunction

	task automatic frame(input string nm, input int n, input int s, input logic en);
		logic [31:0] d;
		logic [15:0] e;
		outq.delete();
		got = 1'b0;
		e = csum(s, n);
		i_rco_mac_src.send(n);
		for (int w = 0; w < 40 && !got; w++) @(posedge core_clk_i);
		if (!got) begin
			chk("timeout", 1, 0);
			finish_test();
		end
		#1;
		chk("stall", 0, i_rco_mac_src.stuck);
		chk("len", n + (en ? 2 : 0), slen);
		chk("count", n + (en ? 2 : 0), outq.size());
		for (int k = 0; k < n; k++) chk("byte", i_rco_mac_src.mem[k], outq[k]);
		if (en) begin
			chk("sum", e, {outq[n + 1], outq[n]});
			rd(4'h8, d);
			chk("sumreg", e, d);
		end
		$display("test %s done", nm);
	endtask

	//------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------
	initial begin
		logic [31:0] d;
		for (int k = 0; k < 64; k++) i_rco_mac_src.mem[k] = 8'(k * 29 + 7);
		setb(14, 8'hff, 8'hff);
		setb(16, 8'hff, 8'hff);
		repeat (10) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		rd(4'h0, d);
		chk("ctrl", 32'h0, d);
		rd(4'h4, d);
		chk("vtag", 32'h8100, d);
		rd(4'h2, d);
		chk("unmapped", 32'h0, d);
		frame("disabled", 23, 14, 1'b0);
		wr(4'h0, 32'h1);
		frame("mode0 odd", 23, 14, 1'b1);
		frame("mode0 even", 24, 14, 1'b1);
		wr(4'h4, 32'h9100);
		wr(4'h0, 32'h3);
		setb(12, 8'h91, 8'h00);
		setb(16, 8'h91, 8'h00);
		setb(20, 8'h91, 8'h00);
		frame("three tags", 31, 22, 1'b1);
		setb(16, 8'h00, 8'h20);
		frame("vlan snap", 33, 26, 1'b1);
		setb(12, 8'h08, 8'h00);
		frame("type two", 23, 14, 1'b1);
		rd(4'h0, d);
		chk("ctrl", 32'h3, d);
		rd(4'hc, d);
		chk("frames", 32'h6, d);
		finish_test();
	end
endmodule // rx_checksum_offload_tb
